// ---- verilog/bridge_mon_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the bridge monitor.
// Assumes: 40 MHz core clock.
// Notes:   Definitions only.
`ifndef BRIDGE_MON_DEFINES_SVH
`define BRIDGE_MON_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_SETUP0      12'h000
`define ADDR_SETUP1      12'h004
`define ADDR_STATUS      12'h008

// First setup word: monitor pin source [1:0], rise count margin [9:2].
`define S0_MON_LSB       0
`define S0_MARGIN_LSB    2
`define SETUP0_RST       10'h020
// Second setup word: open-load level [1:0], peak scale [3:2], scheme [5:4].
`define S1_OL_LSB        0
`define S1_PEAK_LSB      2
`define S1_SCHEME_LSB    4
`define SETUP1_RST       6'h0d

// Status word bit positions above the short fault byte.
`define STAT_OPEN_A      8
`define STAT_OPEN_B      9
`define STAT_BLOCKED     10
`define STAT_SUMMARY     15

// ****************************************************************
// Timing and thresholds
// ****************************************************************
`define CLK_MHZ          40
`define SHORT_DELAY_NS   3000
`define SHORT_DELAY_CYC  ((`SHORT_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define OL_BLANK_NS      1000
`define OL_BLANK_CYC     ((`OL_BLANK_NS * `CLK_MHZ + 999) / 1000)
`define DAC_OL_LIMIT     6'h1f
`define OL_CYCLES        5'h0f

`endif

// ---- verilog/bridge_mon_pkg.sv ----
// Purpose: Types shared by the bridge monitor and its bench.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in bridge_mon_defines.svh.
package bridge_mon_pkg;

  // Source of the fault monitor pin.
  typedef enum logic [1:0] {
    MON_FAULT = 2'b00,
    MON_STALL = 2'b01,
    MON_PWM_A = 2'b10,
    MON_IDLE  = 2'b11
  } monitor_src_t;

  // Stall comparison scheme.
  typedef enum logic [1:0] {
    SCH_OPPOSITE = 2'b00,
    SCH_SAME     = 2'b01
  } scheme_t;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Gate state from the PWM logic, one bit per leg: A+, A-, B+, B-.
  typedef struct packed {
    logic [3:0] hs_on;
    logic [3:0] ls_on;
  } fet_on_t;

endpackage

// ---- verilog/bridge_fault_and_stall_monitor.sv ----
// Purpose: Short, open-load and stall monitoring for a two-phase bridge.
// Assumes: Comparator and pin inputs are asynchronous; gate state, PWM cycle
//          starts, rise windows and DAC values come from logic on clk.
// Notes:   Registers are reached over APB with one wait state.
//
// What this block does
// - Low-side overcurrent while low FET on, held for the delay, confirms supply short.
// - A confirmed short switches its phase output off until a step edge or fault reset.
// - Two low FETs on: internal PWM state picks the shorted connection.
// - Each high FET checked separately; held overcurrent sets its ground-short bit.
// - A shorted load shows high and low short bits of one phase together.
// - Delay timer starts on overcurrent, restarts if it vanishes, latches at expiry.
// - A short disables its whole phase until step edge, clear pin or write.
// - Step or fault reset clears the short part of the summary, re-enables outputs and resamples.
// - A step edge never clears the latched short bits.
// - A persisting short repeats enable then disable on every retry event.
// - Open-load monitoring only while the phase DAC value exceeds 31.
// - Open-load threshold set by level bits scaled by the peak scale bits.
// - Open-load check ignored during a blank time at each PWM cycle start.
// - Open load flagged after more than 15 cycles below threshold, DAC above 31.
// - Open load keeps driving; summary drops when current rises or DAC below 32.
// - Open-load bits stay set until clear pin or a setup write.
// - Stall scheme resets to 00, comparing opposite phases.
// - One PWM cycle counter per phase counts cycles during each current rise.
// - Opposite scheme: rise count against other phase's last, low margin nibble.
// - Scheme 01: rise count against same phase's last, full margin byte.
// - The phase A PWM-on signal can be routed to the fault monitor pin.
// - Reset values give a working block without any register write.
// - Short fault byte holds one latched bit for each of the eight FETs.
// - Every setup register write resets the latched diagnostic bits.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "bridge_mon_defines.svh"

module bridge_fault_and_stall_monitor #(
  parameter int SHORT_CYC = `SHORT_DELAY_CYC,
  parameter int BLANK_CYC = `OL_BLANK_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      clk_en,
  input  wire bridge_mon_pkg::apb_req_t  apb_req,
  output logic [31:0]                    prdata_q,
  output logic                           pready_q,
  output logic                           pslverr_q,
  input  wire logic                      active_low_clear_pin,
  input  wire logic                      step_in,
  input  wire bridge_mon_pkg::fet_on_t   fet_on,
  input  wire logic [1:0]                recirc_dir,
  input  wire logic [1:0]                ls_overcurrent,
  input  wire logic [3:0]                hs_overcurrent,
  input  wire logic [1:0]                ol_below,
  input  wire logic [1:0]                pwm_cycle_start,
  input  wire logic                      pwm_on_a,
  input  wire logic [1:0]                rise_active,
  input  wire logic [5:0]                dac_a,
  input  wire logic [5:0]                dac_b,
  output logic [1:0]                     out_en_q,
  output logic [3:0]                     ol_ref_q,
  output logic                           fault_monitor_pin_b_q
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic [9:0] meta_q;
  logic [9:0] sync_q;
  logic       step_prev_q;
  wire  [9:0] pin_raw = {ol_below, hs_overcurrent, ls_overcurrent,
                         step_in, active_low_clear_pin};

  // Two flops on every asynchronous input; the clear pin idles high.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q      <= 10'h001;
      sync_q      <= 10'h001;
      step_prev_q <= 1'b0;
    end else if (clk_en) begin
      meta_q      <= pin_raw;
      sync_q      <= meta_q;
      step_prev_q <= sync_q[1];
    end
  end

  wire       clr_low   = ~sync_q[0];
  wire       step_rise = sync_q[1] & ~step_prev_q;
  wire [1:0] ls_oc_s   = sync_q[3:2];
  wire [3:0] hs_oc_s   = sync_q[7:4];
  wire [1:0] below_s   = sync_q[9:8];

  // ****************************************************************
  // APB slave
  // ****************************************************************

  logic [9:0]  setup0_q;
  logic [5:0]  setup1_q;
  logic [31:0] status_w;

  // Address decode and the taken write.
  wire acc      = apb_req.psel & apb_req.penable;
  wire hit0     = apb_req.paddr == `ADDR_SETUP0;
  wire hit1     = apb_req.paddr == `ADDR_SETUP1;
  wire hit_st   = apb_req.paddr == `ADDR_STATUS;
  wire bad      = ~(hit0 | hit1 | (hit_st & ~apb_req.pwrite));
  wire cfg_wr   = acc & pready_q & apb_req.pwrite & (hit0 | hit1);

  // Read data selection; the status word is read-only.
  wire [31:0] rdata_d = hit0   ? {22'h00_0000, setup0_q} :
                        hit1   ? {26'h000_0000, setup1_q} :
                        hit_st ? status_w : 32'h0000_0000;

  // Fault reset events: setup write or clear pin, and the wider retry set.
  wire flag_clr = cfg_wr | clr_low;
  wire retry    = flag_clr | step_rise;

  // One wait state: pready is high in the second access cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & bad;
      prdata_q  <= (acc & ~pready_q & ~apb_req.pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // Setup words with working defaults.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup0_q <= `SETUP0_RST;
      setup1_q <= `SETUP1_RST;
    end else if (clk_en && cfg_wr) begin
      if (hit0) begin
        setup0_q <= apb_req.pwdata[9:0];
      end
      if (hit1) begin
        setup1_q <= apb_req.pwdata[5:0];
      end
    end
  end

  // Field views of the setup words.
  wire [1:0] mon_sel    = setup0_q[`S0_MON_LSB +: 2];
  wire [7:0] margin     = setup0_q[`S0_MARGIN_LSB +: 8];
  wire [1:0] ol_level   = setup1_q[`S1_OL_LSB +: 2];
  wire [1:0] peak_scale = setup1_q[`S1_PEAK_LSB +: 2];
  wire       same_sch   = setup1_q[`S1_SCHEME_LSB +: 2] ==
                          bridge_mon_pkg::SCH_SAME;

  // ****************************************************************
  // Short detection, one slice per FET
  // ****************************************************************

  // Bit 2k is the high FET of leg k, bit 2k+1 its low FET.
  logic [7:0] cond;
  logic [7:0] confirm;
  logic [7:0] act_d;
  logic [7:0] act_q;
  logic [7:0] short_q;

  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_fet
      localparam int LEG = k / 2;
      localparam int PH  = k / 4;
      logic [11:0] tmr_q;
      if (k % 2 == 0) begin : g_hs
        // High FET watched on its own current sense.
        assign cond[k] = fet_on.hs_on[LEG] & hs_oc_s[LEG];
      end else begin : g_ls
        // Shared sense: with both low FETs on, the PWM state names the leg.
        wire both = fet_on.ls_on[2*PH] & fet_on.ls_on[2*PH+1];
        wire pick = recirc_dir[PH] == (LEG % 2 == 0);
        assign cond[k] = fet_on.ls_on[LEG] & ls_oc_s[PH] & (~both | pick);
      end
      // Expiry of the delay with the overcurrent still present.
      assign confirm[k] = cond[k] & (tmr_q == 12'(SHORT_CYC - 1));
      // Active short: set wins over the retry clear.
      assign act_d[k] = confirm[k] | (act_q[k] & ~retry);

      // Delay timer restarts whenever the overcurrent drops or a retry occurs.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          tmr_q <= 12'h000;
        end else if (clk_en) begin
          if (!cond[k] || retry) begin
            tmr_q <= 12'h000;
          end else if (tmr_q != 12'(SHORT_CYC - 1)) begin
            tmr_q <= tmr_q + 12'h001;
          end
        end
      end

      // Latched short bit, cleared only by a diagnostic reset.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          short_q[k] <= 1'b0;
        end else if (clk_en) begin
          short_q[k] <= confirm[k] | (short_q[k] & ~flag_clr);
        end
      end
    end
  endgenerate

  // Active short flags and per-phase output enables.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_q    <= 8'h00;
      out_en_q <= 2'b11;
    end else if (clk_en) begin
      act_q    <= act_d;
      out_en_q <= ~{|act_d[7:4], |act_d[3:0]};
    end
  end

  // ****************************************************************
  // Open-load and stall, one slice per phase
  // ****************************************************************

  logic [1:0] ol_act;
  logic [1:0] open_q;
  logic [1:0] stall_hit;
  logic [7:0] last_q [2];
  logic [1:0] last_v_q;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_ph
      logic [11:0] blank_q;
      logic        above_q;
      logic [4:0]  olcnt_q;
      logic        rise_prev_q;
      logic [7:0]  rcnt_q;
      wire  [5:0]  dac      = (p == 0) ? dac_a : dac_b;
      wire         dac_hi   = dac > `DAC_OL_LIMIT;
      wire         blk_done = blank_q == 12'(BLANK_CYC);
      wire         cyc      = pwm_cycle_start[p];
      wire         rise_end = rise_prev_q & ~rise_active[p];
      wire  [7:0]  ref_cnt  = same_sch ? last_q[p] : last_q[1-p];
      wire         ref_ok   = same_sch ? last_v_q[p] : last_v_q[1-p];
      wire  [7:0]  diff     = (rcnt_q > ref_cnt) ? rcnt_q - ref_cnt : ref_cnt - rcnt_q;
      wire  [7:0]  lim      = same_sch ? margin : {4'h0, margin[3:0]};

      // Open load live while below threshold past the cycle count.
      assign ol_act[p]    = dac_hi & ~above_q & (olcnt_q > `OL_CYCLES);
      assign stall_hit[p] = rise_end & ref_ok & (diff > lim);

      // Blank timer and the per-cycle "current rose above threshold" flag.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          blank_q <= 12'h000;
          above_q <= 1'b0;
        end else if (clk_en) begin
          if (cyc) begin
            blank_q <= 12'h000;
            above_q <= 1'b0;
          end else begin
            if (!blk_done) begin
              blank_q <= blank_q + 12'h001;
            end
            if (blk_done && !below_s[p]) begin
              above_q <= 1'b1;
            end
          end
        end
      end

      // Consecutive low cycles, counted at each cycle start.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          olcnt_q <= 5'h00;
        end else if (clk_en) begin
          if (!dac_hi) begin
            olcnt_q <= 5'h00;
          end else if (cyc) begin
            if (above_q) begin
              olcnt_q <= 5'h00;
            end else if (olcnt_q <= `OL_CYCLES) begin
              olcnt_q <= olcnt_q + 5'h01;
            end
          end
        end
      end

      // Latched open-load bit, set wins over the clear.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          open_q[p] <= 1'b0;
        end else if (clk_en) begin
          open_q[p] <= ol_act[p] | (open_q[p] & ~flag_clr);
        end
      end

      // Rise cycle counter; the count is kept at the end of each rise.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          rise_prev_q <= 1'b0;
          rcnt_q      <= 8'h00;
          last_q[p]   <= 8'h00;
          last_v_q[p] <= 1'b0;
        end else if (clk_en) begin
          rise_prev_q <= rise_active[p];
          if (rise_end) begin
            last_q[p]   <= rcnt_q;
            last_v_q[p] <= 1'b1;
            rcnt_q      <= 8'h00;
          end else if (rise_active[p] && cyc && rcnt_q != 8'hff) begin
            rcnt_q <= rcnt_q + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Summary, stall flag, monitor pin and open-load reference
  // ****************************************************************

  logic blocked_q;
  wire  blocked_d = (|stall_hit) | (blocked_q & ~flag_clr);
  wire  summary_d = (|act_d) | (|ol_act);

  // Pin source selection; the pin is low for an active condition.
  wire mon_d = (mon_sel == bridge_mon_pkg::MON_FAULT) ? ~summary_d :
               (mon_sel == bridge_mon_pkg::MON_STALL) ? ~blocked_d :
               (mon_sel == bridge_mon_pkg::MON_PWM_A) ? pwm_on_a  :
               1'b1;

  // Status word as read over the bus.
  assign status_w = {16'h0000, (|act_q) | (|ol_act), 4'h0, blocked_q,
                     open_q[1], open_q[0], short_q};

  // Output flops for the pin, the stall flag and the threshold code.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blocked_q             <= 1'b0;
      fault_monitor_pin_b_q <= 1'b1;
      ol_ref_q              <= 4'h0;
    end else if (clk_en) begin
      blocked_q             <= blocked_d;
      fault_monitor_pin_b_q <= mon_d;
      ol_ref_q              <= {peak_scale, ol_level};
    end
  end

endmodule // bridge_fault_and_stall_monitor

// ---- sim/bridge_mon_monitor.sv ----
// Purpose: Port-level checks of the bridge monitor.
// Assumes: clk_en is taken low only while the bus is idle.
// Notes:   Bound to the design below.
`timescale 1ns/100ps
`include "bridge_mon_defines.svh"
module bridge_mon_monitor #(
  parameter int SHORT_CYC = 4
) (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire bridge_mon_pkg::apb_req_t apb_req,
  input wire logic                     pready_q,
  input wire logic                     pslverr_q,
  input wire logic                     active_low_clear_pin,
  input wire logic                     step_in,
  input wire logic [1:0]               ls_overcurrent,
  input wire logic [3:0]               hs_overcurrent,
  input wire logic                     pwm_on_a,
  input wire logic [1:0]               out_en_q,
  input wire logic [3:0]               ol_ref_q,
  input wire logic                     fault_monitor_pin_b_q
);
  logic       wr_ok;
  logic [7:0] run_a_q, run_b_q;
  logic [3:0] age_q;
  logic [1:0] src_q;
  logic [5:0] s1_q;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A completed write to a setup word, which also acts as a retry.
  assign wr_ok = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_q
                 & (apb_req.paddr < `ADDR_STATUS);

  // Overcurrent run lengths, age of the last retry cause and shadow setup fields.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_a_q <= 8'h00;
      run_b_q <= 8'h00;
      age_q   <= 4'hf;
      src_q   <= 2'h0;
      s1_q    <= `SETUP1_RST;
    end else begin
      run_a_q <= (ls_overcurrent[0] | (|hs_overcurrent[1:0])) ?
                 run_a_q + {7'h00, ~&run_a_q} : 8'h00;
      run_b_q <= (ls_overcurrent[1] | (|hs_overcurrent[3:2])) ?
                 run_b_q + {7'h00, ~&run_b_q} : 8'h00;
      age_q   <= ($rose(step_in) | ~active_low_clear_pin | wr_ok) ? 4'h0 : age_q + {3'h0, ~&age_q};
      if (wr_ok && apb_req.paddr == `ADDR_SETUP0)
        src_q <= apb_req.pwdata[1:0];
      if (wr_ok && apb_req.paddr == `ADDR_SETUP1)
        s1_q <= apb_req.pwdata[5:0];
    end
  end

  a_ready_single : assert property (pready_q |=> !pready_q)
    else $error("ready longer than one cycle");
  a_answer_time : assert property (apb_req.psel && !apb_req.penable
      |=> !pready_q ##1 pready_q)
    else $error("answer not after one wait state");
  a_refuse_bad : assert property (pready_q && (apb_req.paddr > `ADDR_STATUS ||
      apb_req.pwrite && apb_req.paddr == `ADDR_STATUS) |-> pslverr_q)
    else $error("bad access not refused");
  a_short_hold_a : assert property ($fell(out_en_q[0]) |-> run_a_q >= SHORT_CYC)
    else $error("phase A disabled too early");
  a_short_hold_b : assert property ($fell(out_en_q[1]) |-> run_b_q >= SHORT_CYC)
    else $error("phase B disabled too early");
  a_fault_pin : assert property ($fell(out_en_q[0]) && src_q == 2'h0
      |-> ##[0:2] !fault_monitor_pin_b_q)
    else $error("pin not low on short");
  a_retry_cause : assert property ($rose(out_en_q[0]) || $rose(out_en_q[1])
      |-> age_q <= 4'h8)
    else $error("outputs enabled without retry");
  a_ol_ref_map : assert property ($past(rst_b) && $stable(s1_q)
      |-> ol_ref_q == s1_q[3:0])
    else $error("threshold select wrong");
  a_pwm_route : assert property ($past(src_q) == 2'h2 && $past(src_q, 2) == 2'h2
      && $changed(fault_monitor_pin_b_q) |-> $past(pwm_on_a) != $past(pwm_on_a, 2))
    else $error("pin does not follow pwm");
endmodule // bridge_mon_monitor

bind bridge_fault_and_stall_monitor bridge_mon_monitor #(.SHORT_CYC(SHORT_CYC)) u_mon (
  .clk, .rst_b, .apb_req, .pready_q, .pslverr_q, .active_low_clear_pin, .step_in,
  .ls_overcurrent, .hs_overcurrent, .pwm_on_a, .out_en_q, .ol_ref_q, .fault_monitor_pin_b_q
);

// ---- sim/bridge_partner_model.sv ----
// Purpose: Behavioural bridge and motor around the monitor.
// Assumes: Faults are commanded by the bench.
// Notes:   Fault current only flows while the phase is enabled.
`timescale 1ns/100ps
module bridge_partner_model (
  input  wire logic                    clk,
  input  wire bridge_mon_pkg::fet_on_t fet_on,
  input  wire logic [1:0]              out_en_q,
  input  wire logic                    short_a,
  input  wire logic                    short_b,
  input  wire logic                    open_b,
  output logic [1:0]                   ls_overcurrent,
  output logic [3:0]                   hs_overcurrent,
  output logic [1:0]                   ol_below,
  output logic [1:0]                   pwm_cycle_start,
  output logic                         pwm_on_a
);
  logic [2:0] pwm_q = 3'h0;

  // Free-running PWM period of eight clocks.
  always @(posedge clk) begin
    pwm_q <= pwm_q + 3'h1;
  end

  // Cycle starts, phase A on-time and comparators; a load short hits both sides at once.
  assign pwm_cycle_start = {2{pwm_q == 3'h0}};
  assign pwm_on_a        = pwm_q < 3'h3;
  assign ls_overcurrent  = {short_b & out_en_q[1] & (|fet_on.ls_on[3:2]),
                            short_a & out_en_q[0] & (|fet_on.ls_on[1:0])};
  assign hs_overcurrent  = {1'b0, short_b & out_en_q[1] & fet_on.hs_on[2], 2'h0};
  assign ol_below        = {open_b, 1'b0};
endmodule // bridge_partner_model

// ---- sim/bridge_fault_and_stall_monitor_tb_top.sv ----
// Purpose: Self-checking bench of the bridge monitor.
// Assumes: Short delay of 4 clocks, blank time of 2 clocks.
// Notes:   Inputs change right after rising edges.
`timescale 1ns/100ps
`include "bridge_mon_defines.svh"
module bridge_fault_and_stall_monitor_tb_top;
  bridge_mon_pkg::apb_req_t apb_req;
  bridge_mon_pkg::fet_on_t  fet_on;
  logic                     clk, rst_b, clk_en, pready_q, pslverr_q, step_in, pwm_on_a, er;
  logic                     active_low_clear_pin, fault_monitor_pin_b_q, short_a, short_b, open_b;
  logic [1:0]               recirc_dir, ls_overcurrent, ol_below, pwm_cycle_start;
  logic [1:0]               rise_active, out_en_q;
  logic [3:0]               hs_overcurrent, ol_ref_q;
  logic [5:0]               dac_a, dac_b;
  logic [31:0]              prdata_q, r;
  int                       n_mismatch, n_checks;

  bridge_fault_and_stall_monitor #(.SHORT_CYC(4), .BLANK_CYC(2)) DUT (
    .clk, .rst_b, .clk_en, .apb_req, .prdata_q, .pready_q, .pslverr_q, .active_low_clear_pin,
    .step_in, .fet_on, .recirc_dir, .ls_overcurrent, .hs_overcurrent, .ol_below,
    .pwm_cycle_start, .pwm_on_a, .rise_active, .dac_a, .dac_b, .out_en_q, .ol_ref_q,
    .fault_monitor_pin_b_q
  );
  bridge_partner_model u_bridge (
    .clk, .fet_on, .out_en_q, .short_a, .short_b, .open_b, .ls_overcurrent,
    .hs_overcurrent, .ol_below, .pwm_cycle_start, .pwm_on_a
  );

  // Clock of 25 ns.
  always #12.5 clk = ~clk;

  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic give_up;
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    end_sim();
  endtask

  // One APB transfer, held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (n >= 20) give_up();
    r = prdata_q;
    er = pslverr_q;
    apb_req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(r[15:0] & m, e);
  endtask

  task automatic wait_en(input int p, input logic v);
    int n;
    n = 0;
    while (out_en_q[p] !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) give_up();
  endtask

  task automatic pulse_step;
    @(posedge clk);
    step_in <= 1'b1;
    repeat (4) @(posedge clk);
    step_in <= 1'b0;
  endtask

  // Rise window of n PWM cycles, aligned just after a cycle start.
  task automatic rise(input int p, input int n);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pwm_cycle_start[0] !== 1'b1 && k < 20);
    rise_active[p] <= 1'b1;
    repeat (8 * n) @(posedge clk);
    rise_active[p] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset;
    repeat (3) @(posedge clk);
    chk(16'(out_en_q), 16'h0003);
    chk(16'(ol_ref_q), 16'h000d);
    rd(`ADDR_SETUP0, 16'hffff, 16'h0020);
    rd(`ADDR_SETUP1, 16'h0030, 16'h0000);
    rd(12'h00c, 16'hffff, 16'h0000);
    chk(16'(er), 16'h0001);
    apb(1'b1, `ADDR_STATUS, 32'h0000_ffff);
    chk(16'(er), 16'h0001);
  endtask

  task automatic t_short;
    @(posedge clk);
    fet_on.ls_on <= 4'h1;
    short_a <= 1'b1;
    repeat (3) @(posedge clk);
    short_a <= 1'b0;
    repeat (10) @(posedge clk);
    chk(16'(out_en_q), 16'h0003);
    // A frozen block must not qualify an overcurrent, however long it lasts.
    clk_en <= 1'b0;
    short_a <= 1'b1;
    repeat (10) @(posedge clk);
    chk(16'(out_en_q), 16'h0003);
    clk_en <= 1'b1;
    short_a <= 1'b0;
    repeat (4) @(posedge clk);
    short_a <= 1'b1;
    wait_en(0, 1'b0);
    @(posedge clk);
    chk(16'(out_en_q), 16'h0002);
    chk(16'(fault_monitor_pin_b_q), 16'h0000);
    rd(`ADDR_STATUS, 16'h80ff, 16'h8002);
    pulse_step();
    wait_en(0, 1'b1);
    wait_en(0, 1'b0);
    short_a <= 1'b0;
    pulse_step();
    wait_en(0, 1'b1);
    rd(`ADDR_STATUS, 16'h80ff, 16'h0002);
    active_low_clear_pin <= 1'b0;
    repeat (4) @(posedge clk);
    active_low_clear_pin <= 1'b1;
    rd(`ADDR_STATUS, 16'hffff, 16'h0000);
  endtask

  task automatic t_recirc;
    for (int d = 0; d < 2; d++) begin
      @(posedge clk);
      fet_on.ls_on <= 4'h3;
      recirc_dir <= {1'b0, d[0]};
      short_a <= 1'b1;
      wait_en(0, 1'b0);
      short_a <= 1'b0;
      rd(`ADDR_STATUS, 16'h00ff, d ? 16'h0002 : 16'h0008);
      apb(1'b1, `ADDR_SETUP1, 32'h0000_000d);
      rd(`ADDR_STATUS, 16'hffff, 16'h0000);
      wait_en(0, 1'b1);
    end
    fet_on <= '{hs_on: 4'h4, ls_on: 4'h8};
    short_b <= 1'b1;
    wait_en(1, 1'b0);
    chk(16'(out_en_q), 16'h0001);
    rd(`ADDR_STATUS, 16'h00ff, 16'h0090);
    short_b <= 1'b0;
    apb(1'b1, `ADDR_SETUP0, 32'h0000_0020);
  endtask

  task automatic t_open;
    @(posedge clk);
    open_b <= 1'b1;
    dac_b <= 6'h1f;
    repeat (200) @(posedge clk);
    rd(`ADDR_STATUS, 16'h8200, 16'h0000);
    dac_b <= 6'h20;
    repeat (96) @(posedge clk);
    rd(`ADDR_STATUS, 16'h8200, 16'h0000);
    repeat (64) @(posedge clk);
    rd(`ADDR_STATUS, 16'h8200, 16'h8200);
    chk(16'(fault_monitor_pin_b_q), 16'h0000);
    dac_b <= 6'h1f;
    rd(`ADDR_STATUS, 16'h8200, 16'h0200);
    open_b <= 1'b0;
    apb(1'b1, `ADDR_SETUP0, 32'h0000_0049);
    rd(`ADDR_STATUS, 16'h0200, 16'h0000);
  endtask

  task automatic t_stall;
    rise(0, 3);
    rise(1, 5);
    rd(`ADDR_STATUS, 16'h0400, 16'h0000);
    rise(0, 8);
    rd(`ADDR_STATUS, 16'h0400, 16'h0400);
    chk(16'(fault_monitor_pin_b_q), 16'h0000);
    apb(1'b1, `ADDR_SETUP1, 32'h0000_001d);
    rise(0, 3);
    rise(0, 5);
    rise(0, 8);
    rd(`ADDR_STATUS, 16'h0400, 16'h0000);
    rise(0, 30);
    rd(`ADDR_STATUS, 16'h0400, 16'h0400);
    apb(1'b1, `ADDR_SETUP0, 32'h0000_0022);
    repeat (2) @(posedge clk);
    // The pin repeats the phase A on-time one clock late.
    for (int i = 0; i < 16; i++) begin
      er = pwm_on_a;
      @(posedge clk);
      chk(16'(fault_monitor_pin_b_q), 16'(er));
    end
  endtask

  // Reset for six cycles, then every scenario in turn.
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    apb_req = '0;
    active_low_clear_pin = 1'b1;
    {step_in, short_a, short_b, open_b} = 4'h0;
    {fet_on, recirc_dir, rise_active, dac_a, dac_b} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_short();
    t_recirc();
    t_open();
    t_stall();
    end_sim();
  end
endmodule // bridge_fault_and_stall_monitor_tb_top
